// ===== design/rsc_pkg.sv
`default_nettype none
package rsc_pkg;
    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_CONFIG = 10'h080; // Option settings
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h081; // Sticky events, read only
    localparam logic [9:0] IDX_IRQ_CLEAR = 10'h082; // Write one to clear
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h083; // Event mask
    localparam logic [9:0] IDX_SUPPLY = 10'h084; // Supply flags and sequence state
    localparam logic [9:0] IDX_GPIO = 10'h085; // Shared pin as port bit
    localparam logic [9:0] IDX_PROG_FLAGS = 10'h086; // Program status flags

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CFG_HI_LSB = 0; // High-speed prescaler select, 3 bits
    localparam int CFG_LO_LSB = 3; // Low-speed prescaler select, 2 bits
    localparam int CFG_PIN_RST = 5; // 1 = pin is reset input
    localparam int CFG_SECURE = 6; // 1 = read-out blocked
    localparam int CFG_LVD_LSB = 7; // Detector level, 2 bits
    localparam int PF_POR = 7;
    localparam int PF_WDT = 6;
    localparam int PF_EXT = 5;
    localparam int PF_STK = 4;
    localparam int GPIO_OUT = 0;
    localparam int GPIO_OE = 1;
    localparam int GPIO_IN = 2;
    localparam int EV_BROWNOUT = 0;
    localparam int EV_WDT = 1;
    localparam int EV_EXT = 2;
    localparam int EV_UPPER = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [8:0] CONFIG_RST = 9'h020; // Div 1, pin reset, no security, low
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
    localparam logic [1:0] GPIO_RST = 2'h0;

    // ----------------------------------------------------------------
    // Detector levels
    // ----------------------------------------------------------------
    localparam logic [1:0] LVD_LOW = 2'h0;
    localparam logic [1:0] LVD_MID = 2'h1;
    localparam logic [1:0] LVD_HIGH = 2'h2;
    localparam logic [1:0] LVD_TOP = 2'h3;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50; // 20 MHz
    localparam int WARM_TIME_NS = 10000; // Oscillator warm-up, least
    localparam int WARM_CYCLES = (WARM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Reset sequence states
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_POWER_UP = 3'b000,
        ST_PIN_WAIT = 3'b001,
        ST_INIT = 3'b010,
        ST_WARM = 3'b011,
        ST_RUN = 3'b100
    } rsc_state_t;
endpackage
`default_nettype wire

// ===== design/rsc_top.sv
// Operation
// - Normal mode clock divides high oscillator 1..128
// - Slow mode divides low RC by 1/2/4/8
// - Pin falling edge resets system in reset mode
// - GPIO mode disables pin reset, bidirectional bit
// - Security option blocks program memory read-out
// - Max level resets below upper detector level
// - High level enables upper low-supply flag
// - Four reset sources, pin only when enabled
// - Reset clears core flags, stops, clears counter; only nrst restores the option, port and mask registers
// - After release, fetch starts at address zero
// - Top flag marks power-on or brown-out reset
// - Watchdog flag marks watchdog reset
// - Pin flag marks external pin reset
// - Power-up waits for stable supply first
// - Power-up in reset mode holds reset until pin is high
// - Wait oscillator warm-up before running
// - Detector reset clears both low-supply flags
`default_nettype none
module rsc_top
    import rsc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Supply monitor
    input wire logic supply_stable,
    input wire logic below_min_level,
    input wire logic below_lower_level,
    input wire logic below_upper_level,
    // Clock sources and core
    input wire logic osc_ready,
    input wire logic slow_mode,
    input wire logic wdt_overflow,
    input wire logic stack_overflow_flag,
    output logic core_reset_n,
    output logic boot_pulse,
    output logic ins_clk_en,
    output logic readout_lock,
    output logic irq,
    // Shared reset pin
    input wire logic rst_pin_in,
    output logic port2_bit2_io_out,
    output logic port2_bit2_io_oe
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_ff; // First stage, read only by second
    logic rst_sync_ff; // Second stage
    wire rst_n = rst_sync_ff; // Released reset for the rest of the block

    // Two-stage release keeps the deassertion clean
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // State declarations
    // ----------------------------------------------------------------
    rsc_state_t state_ff; // Sequence state
    rsc_state_t nxt_state;
    logic [8:0] cfg_ff; // Option settings
    logic [3:0] irq_stat_ff; // Sticky events
    logic [3:0] irq_en_ff; // Event mask
    logic [1:0] gpio_ff; // Port bit out and enable
    logic [2:0] alu_flags_ff; // Carry, half carry, zero
    logic por_flag_ff; // Cause: power-on or brown-out
    logic wdt_flag_ff; // Cause: watchdog
    logic ext_flag_ff; // Cause: pin
    logic upper_flag_ff; // Upper low-supply indicator
    logic lower_flag_ff; // Lower low-supply indicator
    logic [7:0] warm_cnt_ff; // Warm-up countdown
    logic [6:0] presc_cnt_ff; // Instruction clock divider
    logic pin_meta_ff; // Pin sync, first stage
    logic pin_sync_ff; // Pin sync, second stage
    logic pin_prev_ff; // Previous synced level
    logic wr_pend_ff; // Write data phase pending
    logic [9:0] wr_idx_ff; // Index of pending write
    logic [31:0] hrdata_ff;
    logic core_run_ff;
    logic boot_ff;
    logic ins_clk_ff;

    // ----------------------------------------------------------------
    // Option decoding
    // ----------------------------------------------------------------
    wire [2:0] hi_sel = cfg_ff[CFG_HI_LSB +: 3];
    wire [1:0] lo_sel = cfg_ff[CFG_LO_LSB +: 2];
    wire pin_is_reset = cfg_ff[CFG_PIN_RST];
    wire [1:0] lvd_opt = cfg_ff[CFG_LVD_LSB +: 2];

    // Divider terminal count for a power-of-two divisor
    function automatic logic [6:0] div_limit(input logic [2:0] sel);
        div_limit = 7'(({7'h00, 1'b1} << sel) - 8'h01);
    endfunction

    // Slow mode uses the low RC selector, else the high one
    wire [6:0] presc_lim = slow_mode ? div_limit({1'b0, lo_sel}) : div_limit(hi_sel);

    // ----------------------------------------------------------------
    // Reset sources
    // ----------------------------------------------------------------
    // Pin passes two flops before any edge logic sees it
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_ff <= 1'b1;
            pin_sync_ff <= 1'b1;
            pin_prev_ff <= 1'b1;
        end
        else
        begin
            pin_meta_ff <= rst_pin_in;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    wire pin_fall = pin_prev_ff & ~pin_sync_ff;
    // Pin counts in reset mode; in power-up it must not bypass the supply wait
    wire pin_req = pin_is_reset & pin_fall & (state_ff != ST_POWER_UP);
    // Minimum level always resets; upper levels by option
    wire brownout_req = below_min_level
        | ((lvd_opt == LVD_HIGH) & below_lower_level)
        | ((lvd_opt == LVD_TOP) & below_upper_level);
    wire wdt_req = wdt_overflow & (state_ff == ST_RUN);
    wire any_req = brownout_req | wdt_req | pin_req;

    // ----------------------------------------------------------------
    // Reset sequence
    // ----------------------------------------------------------------
    // Brown-out outranks watchdog, which outranks the pin
    always_comb
    begin
        nxt_state = state_ff;
        if (brownout_req)
        begin
            nxt_state = ST_POWER_UP;
        end
        else if (wdt_req)
        begin
            nxt_state = ST_INIT;
        end
        else if (pin_req)
        begin
            nxt_state = ST_PIN_WAIT;
        end
        else
        begin
            unique case (state_ff)
                ST_POWER_UP:
                begin
                    // Nothing moves until the supply has settled
                    if (supply_stable)
                        nxt_state = pin_is_reset ? ST_PIN_WAIT : ST_INIT;
                end
                ST_PIN_WAIT:
                begin
                    // Held while the pin is still driven low
                    if (pin_sync_ff || !pin_is_reset)
                        nxt_state = ST_INIT;
                end
                ST_INIT:
                begin
                    nxt_state = ST_WARM;
                end
                ST_WARM:
                begin
                    // Clock must be good and the warm-up spent
                    if (osc_ready && warm_cnt_ff == 8'h00)
                        nxt_state = ST_RUN;
                end
                ST_RUN:
                begin
                    nxt_state = ST_RUN;
                end
                default:
                begin
                    nxt_state = ST_POWER_UP;
                end
            endcase
        end
    end

    // State, run level and boot strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_POWER_UP;
            core_run_ff <= 1'b0;
            boot_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            core_run_ff <= (nxt_state == ST_RUN);
            boot_ff <= (nxt_state == ST_RUN) && !core_run_ff;
        end
    end

    // Warm-up counter, reloaded each time the sequence initialises
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            warm_cnt_ff <= 8'(WARM_CYCLES - 1);
        else if (state_ff == ST_INIT)
            warm_cnt_ff <= 8'(WARM_CYCLES - 1);
        else if (state_ff == ST_WARM && warm_cnt_ff != 8'h00)
            warm_cnt_ff <= warm_cnt_ff - 8'h01;
    end

    // ----------------------------------------------------------------
    // Cause flags and supply indicators
    // ----------------------------------------------------------------
    // Reset by nrst counts as power-on; each later cause replaces all
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_flag_ff <= 1'b1;
            wdt_flag_ff <= 1'b0;
            ext_flag_ff <= 1'b0;
        end
        else if (any_req)
        begin
            por_flag_ff <= brownout_req;
            wdt_flag_ff <= !brownout_req && wdt_req;
            ext_flag_ff <= !brownout_req && !wdt_req;
        end
    end

    wire upper_en = (lvd_opt == LVD_HIGH) || (lvd_opt == LVD_TOP);
    wire lower_en = (lvd_opt != LVD_LOW);

    // Flags follow the detectors; a detector reset wipes both
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            upper_flag_ff <= 1'b0;
            lower_flag_ff <= 1'b0;
        end
        else if (brownout_req)
        begin
            upper_flag_ff <= 1'b0;
            lower_flag_ff <= 1'b0;
        end
        else
        begin
            upper_flag_ff <= upper_en & below_upper_level;
            lower_flag_ff <= lower_en & below_lower_level;
        end
    end

    // ----------------------------------------------------------------
    // Instruction clock enable
    // ----------------------------------------------------------------
    // Divider held at zero outside run, so it restarts in phase
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            presc_cnt_ff <= 7'h00;
            ins_clk_ff <= 1'b0;
        end
        else if (!core_run_ff || presc_cnt_ff >= presc_lim)
        begin
            presc_cnt_ff <= 7'h00;
            ins_clk_ff <= core_run_ff;
        end
        else
        begin
            presc_cnt_ff <= presc_cnt_ff + 7'h01;
            ins_clk_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire addr_phase = hsel & htrans[1] & hready;
    wire in_map = (haddr[31:12] == 20'h00000);
    wire [9:0] rd_idx = haddr[11:2];
    wire wr_prog = wr_pend_ff && wr_idx_ff == IDX_PROG_FLAGS;
    wire wr_cfg = wr_pend_ff && wr_idx_ff == IDX_CONFIG;
    wire wr_clr = wr_pend_ff && wr_idx_ff == IDX_IRQ_CLEAR;
    wire wr_en = wr_pend_ff && wr_idx_ff == IDX_IRQ_ENABLE;
    wire wr_gpio = wr_pend_ff && wr_idx_ff == IDX_GPIO;

    wire [7:0] prog_rd = {por_flag_ff, wdt_flag_ff, ext_flag_ff, stack_overflow_flag,
                           1'b0, alu_flags_ff};
    wire [7:0] supply_rd = {3'h0, state_ff, upper_flag_ff, lower_flag_ff};
    wire [2:0] gpio_rd = {pin_sync_ff, gpio_ff};

    // Unmapped and write-only locations read as zero
    wire [31:0] rd_word =
        !in_map ? 32'h0000_0000 :
        (rd_idx == IDX_PROG_FLAGS) ? {24'h000000, prog_rd} :
        (rd_idx == IDX_CONFIG) ? {23'h000000, cfg_ff} :
        (rd_idx == IDX_IRQ_STATUS) ? {28'h0000000, irq_stat_ff} :
        (rd_idx == IDX_IRQ_ENABLE) ? {28'h0000000, irq_en_ff} :
        (rd_idx == IDX_SUPPLY) ? {24'h000000, supply_rd} :
        (rd_idx == IDX_GPIO) ? {29'h00000000, gpio_rd} :
        32'h0000_0000;

    // Zero wait: read data captured in the address phase
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 10'h000;
            hrdata_ff <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_ff <= addr_phase & hwrite & in_map;
            wr_idx_ff <= rd_idx;
            hrdata_ff <= (addr_phase && !hwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    // Options and pin port; bus state survives internal resets
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_ff <= CONFIG_RST;
            gpio_ff <= GPIO_RST;
            irq_en_ff <= IRQ_EN_RST;
        end
        else
        begin
            if (wr_cfg)
                cfg_ff <= hwdata[8:0];
            if (wr_gpio)
                gpio_ff <= hwdata[1:0];
            if (wr_en)
                irq_en_ff <= hwdata[3:0];
        end
    end

    // Core flags return to zero whenever the sequence initialises
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            alu_flags_ff <= 3'h0;
        else if (state_ff == ST_INIT || any_req)
            alu_flags_ff <= 3'h0;
        else if (wr_prog)
            alu_flags_ff <= hwdata[2:0];
    end

    // ----------------------------------------------------------------
    // Interrupt events
    // ----------------------------------------------------------------
    wire upper_rise = upper_en & below_upper_level & ~upper_flag_ff & ~brownout_req;
    wire [3:0] ev_set;
    assign ev_set[EV_BROWNOUT] = brownout_req;
    assign ev_set[EV_WDT] = wdt_req;
    assign ev_set[EV_EXT] = pin_req;
    assign ev_set[EV_UPPER] = upper_rise;
    wire [3:0] ev_clr = wr_clr ? hwdata[3:0] : 4'h0;

    // A new event in the clearing cycle stays set
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_stat_ff <= 4'h0;
        else
            irq_stat_ff <= (irq_stat_ff & ~ev_clr) | ev_set;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign core_reset_n = core_run_ff;
    assign boot_pulse = boot_ff;
    assign ins_clk_en = ins_clk_ff;
    assign irq = |(irq_stat_ff & irq_en_ff);
    assign readout_lock = cfg_ff[CFG_SECURE];
    // Pin driven only while it serves as a port bit
    assign port2_bit2_io_out = gpio_ff[GPIO_OUT];
    assign port2_bit2_io_oe = gpio_ff[GPIO_OE] & ~pin_is_reset;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_bo_cause: assert property (brownout_req |=> por_flag_ff && !wdt_flag_ff
        && !ext_flag_ff && state_ff == ST_POWER_UP)
        else $error("brown-out did not restart with power-on cause");
    a_wdt_cause: assert property (wdt_req && !brownout_req |=> wdt_flag_ff
        && !por_flag_ff && !ext_flag_ff && !core_run_ff)
        else $error("watchdog cause not recorded alone");
    a_pin_cause: assert property (pin_req && !brownout_req && !wdt_req
        |=> ext_flag_ff && state_ff == ST_PIN_WAIT && !core_run_ff)
        else $error("pin reset not taken");
    a_lvd_clear: assert property (brownout_req |=> !upper_flag_ff && !lower_flag_ff)
        else $error("low-supply flags survived detector reset");
    a_pin_hold: assert property (state_ff == ST_PIN_WAIT && !pin_sync_ff && pin_is_reset
        |=> state_ff == ST_PIN_WAIT || state_ff == ST_POWER_UP)
        else $error("left pin wait while pin low");
    a_warm_wait: assert property ($rose(core_run_ff) |-> $past(osc_ready)
        && $past(warm_cnt_ff) == 8'h00)
        else $error("run began before warm-up");
    a_boot_start: assert property ($rose(core_run_ff) |-> boot_pulse ##1 !boot_pulse)
        else $error("boot strobe wrong");
    a_init_clear: assert property (state_ff == ST_INIT |=> alu_flags_ff == 3'h0)
        else $error("core flags not cleared");
    a_presc_gap: assert property (ins_clk_ff && presc_lim != 7'h00
        && $stable(presc_lim) |=> !ins_clk_ff)
        else $error("instruction clock enable too dense");
    a_gpio_mode: assert property (!pin_is_reset && pin_fall && !brownout_req && !wdt_req
        |=> $stable(ext_flag_ff))
        else $error("pin reset in port mode");
    a_supply_wait: assert property (state_ff == ST_POWER_UP && !supply_stable
        |=> state_ff == ST_POWER_UP)
        else $error("power-up advanced early");

endmodule
`default_nettype wire

// ===== tb/rsc_far.sv
`default_nettype none
module rsc_far
(
    // Bench controls
    input wire logic pwr,
    input wire logic pin_lo,
    input wire logic [1:0] sag,
    // Design pin side
    input wire logic io_out,
    input wire logic io_oe,
    // Monitor and pin outputs
    output logic supply_stable,
    output logic below_min_level,
    output logic below_lower_level,
    output logic below_upper_level,
    output logic rst_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------
    // Supply monitor, deeper sag trips every shallower level
    // ----------------------------------------------------------
    assign supply_stable = pwr;
    assign below_upper_level = (sag != 2'h0);
    assign below_lower_level = sag[1];
    assign below_min_level = (sag == 2'h3);
    // Pull-up wins when nobody drives; released pin goes high
    assign rst_pin_in = io_oe ? io_out : !pin_lo;
endmodule
`default_nettype wire

// ===== tb/test_rsc_top.sv
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
module test_rsc_top
    import rsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    logic ref_clk = 0, nrst = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [1:0] htrans = 2'h0, sag = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic pwr = 0, pin_lo = 1, osc_ready = 0, slow_mode = 0, wdt_overflow = 0; // Pin low at power-up
    logic sup, bmin, blow, bup, pin, core_reset_n, boot_pulse, ins_clk_en;
    logic readout_lock, irq, io_out, io_oe;
    int n_errors = 0, n_tests = 0, cyc = 0, n;
    localparam logic [31:0] A_CFG = {20'h0, IDX_CONFIG, 2'b00};
    localparam logic [31:0] A_ST = {20'h0, IDX_IRQ_STATUS, 2'b00};
    localparam logic [31:0] A_CLR = {20'h0, IDX_IRQ_CLEAR, 2'b00};
    localparam logic [31:0] A_EN = {20'h0, IDX_IRQ_ENABLE, 2'b00};
    localparam logic [31:0] A_SUP = {20'h0, IDX_SUPPLY, 2'b00};
    localparam logic [31:0] A_IO = {20'h0, IDX_GPIO, 2'b00};
    localparam logic [31:0] A_PF = {20'h0, IDX_PROG_FLAGS, 2'b00};
    assign hready = hreadyout; // Single slave
    always #25 ref_clk = ~ref_clk;
    rsc_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .supply_stable(sup),
        .below_min_level(bmin), .below_lower_level(blow), .below_upper_level(bup),
        .osc_ready(osc_ready), .slow_mode(slow_mode), .wdt_overflow(wdt_overflow),
        .stack_overflow_flag(1'b0), .core_reset_n(core_reset_n), .boot_pulse(boot_pulse),
        .ins_clk_en(ins_clk_en), .readout_lock(readout_lock), .irq(irq),
        .rst_pin_in(pin), .port2_bit2_io_out(io_out), .port2_bit2_io_oe(io_oe));
    rsc_far far_u (.pwr(pwr), .pin_lo(pin_lo), .sag(sag), .io_out(io_out), .io_oe(io_oe),
        .supply_stable(sup), .below_min_level(bmin), .below_lower_level(blow),
        .below_upper_level(bup), .rst_pin_in(pin));
    // ----------------------------------------------------------
    // Bus tasks, hold each phase until hready is sampled high
    // ----------------------------------------------------------
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        d = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, d)
        `CHK("hresp", 1'b0, hresp)
    endtask
    // Wait for run with a bound, count cycles spent in reset
    task automatic run_wait();
        n = 0;
        repeat (2000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
            if (core_reset_n === 1'b1) break;
        end
        `CHK("boot", 1'b1, boot_pulse)
    endtask
    // Period of the instruction clock enable, after two pulses to settle
    task automatic per(input int e);
        int c;
        c = 0;
        repeat (2) repeat (300)
        begin
            @(posedge ref_clk);
            #1;
            if (ins_clk_en === 1'b1) break;
        end
        repeat (300)
        begin
            @(posedge ref_clk);
            #1;
            c++;
            if (ins_clk_en === 1'b1) break;
        end
        `CHK("period", e, c)
    endtask
    task automatic results();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hang guard, far above the expected run length
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            results();
        end
    end
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1;
        repeat (20) @(posedge ref_clk);
        `CHK("hold", 1'b0, core_reset_n)
        `CHK("no lock", 1'b0, readout_lock)
        rd(A_PF, 32'h80, "flags por");
        rd(A_CFG, 32'h20, "cfg rst");
        pwr <= 1;
        repeat (20) @(posedge ref_clk);
        rd(A_SUP, 32'h4, "pin wait");
        pin_lo <= 0;
        repeat (250) @(posedge ref_clk);
        `CHK("no osc", 1'b0, core_reset_n)
        osc_ready <= 1;
        run_wait();
        $display("power-up done");
        bus(1'b1, A_EN, 32'h4);
        bus(1'b1, A_PF, 32'h7);
        pin_lo <= 1;
        repeat (10) @(posedge ref_clk);
        `CHK("pin rst", 1'b0, core_reset_n)
        pin_lo <= 0;
        run_wait();
        `CHK("warm", 1'b1, n >= 200)
        rd(A_PF, 32'h20, "flags pin");
        `CHK("irq", 1'b1, irq)
        rd(A_ST, 32'h4, "status");
        bus(1'b1, A_CLR, 32'hF);
        rd(A_CLR, 32'h0, "clr wo");
        `CHK("irq clr", 1'b0, irq)
        rd(32'h1000, 32'h0, "unmapped");
        $display("pin reset done");
        wdt_overflow <= 1;
        @(posedge ref_clk);
        wdt_overflow <= 0;
        run_wait();
        rd(A_PF, 32'h40, "flags wdt");
        bus(1'b1, A_CFG, 32'h0);
        bus(1'b1, A_IO, 32'h3);
        @(posedge ref_clk); // Write lands on the edge that ends the task
        `CHK("oe", 2'h3, {io_oe, io_out})
        bus(1'b1, A_IO, 32'h0);
        pin_lo <= 1;
        repeat (10) @(posedge ref_clk);
        `CHK("io no rst", 1'b1, core_reset_n)
        rd(A_IO, 32'h0, "io in");
        pin_lo <= 0;
        bus(1'b1, A_CFG, 32'h60);
        @(posedge ref_clk);
        `CHK("lock", 1'b1, readout_lock)
        $display("gpio and security done");
        for (int s = 0; s < 8; s++)
        begin
            bus(1'b1, A_CFG, 32'h20 | s);
            per(1 << s);
        end
        @(posedge ref_clk);
        slow_mode <= 1;
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, A_CFG, 32'h20 | (s << 3));
            per(1 << s);
        end
        @(posedge ref_clk);
        slow_mode <= 0;
        $display("prescaler done");
        bus(1'b1, A_CFG, 32'hA0);
        sag <= 2'h2;
        repeat (5) @(posedge ref_clk);
        rd(A_SUP, 32'h11, "lower flag");
        sag <= 2'h1;
        bus(1'b1, A_CFG, 32'h120);
        repeat (5) @(posedge ref_clk);
        rd(A_SUP, 32'h12, "upper flag");
        bus(1'b1, A_CFG, 32'h1A0);
        repeat (5) @(posedge ref_clk);
        `CHK("max rst", 1'b0, core_reset_n)
        rd(A_SUP, 32'h0, "bo flags");
        sag <= 2'h0;
        run_wait();
        rd(A_PF, 32'h80, "flags bor");
        rd(A_SUP, 32'h10, "flags clr");
        $display("detector done");
        results();
    end
endmodule
`default_nettype wire
